/* File: include/tx_cmd_pkg.sv */
// Purpose: shared constants for the transmit command decoder and its host end
// Assumes: 32-bit command and data words, one clock at 250 MHz
// Notes:   field positions of the first command word and the host register map
//
// Notes on behaviour
// - completion request raises buffer-loaded once buffer consumed
// - buffer-loaded can reach interrupt under host mask
// - host keeps reserved command bits at zero
// - end alignment codes: 4, 16, 32 bytes
// - host pads to alignment, device drops padding
// - start offset skips leading bytes, 0 to 31
// - first-segment bit opens a new packet
// - last-segment bit closes the open packet
// - buffer size plus alignment give padding words
// - buffer sizes summed, compared with packet length
// - count mismatch raises transmitter error
// - order is command one, command two, data
// - packet length excludes offset and padding bytes
package tx_cmd_pkg;

    // ********
    // first command word fields
    // ********
    localparam int IOC_BIT      = 31;
    localparam int ALIGN_HI     = 25;
    localparam int ALIGN_LO     = 24;
    localparam int OFF_HI       = 20;
    localparam int OFF_LO       = 16;
    localparam int FIRST_BIT    = 13;
    localparam int LAST_BIT     = 12;
    localparam int SIZE_HI      = 10;
    localparam int LEN_HI       = 10;

    localparam logic [1:0] ALIGN_4  = 2'h0;
    localparam logic [1:0] ALIGN_16 = 2'h1;
    localparam logic [1:0] ALIGN_32 = 2'h2;

    // rounding masks in words for each alignment
    localparam logic [11:0] MASK_4  = 12'h000;
    localparam logic [11:0] MASK_16 = 12'h003;
    localparam logic [11:0] MASK_32 = 12'h007;

    // ********
    // host register map (byte addresses)
    // ********
    localparam logic [7:0] REG_TX_WORD    = 8'h00;
    localparam logic [7:0] REG_INT_STATUS = 8'h04;
    localparam logic [7:0] REG_INT_MASK   = 8'h08;
    localparam logic [7:0] REG_LINK_STATE = 8'h0C;

    localparam int STS_LOADED = 0;
    localparam int STS_ERROR  = 1;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        ST_CMD_A = 2'b00,
        ST_CMD_B = 2'b01,
        ST_DATA  = 2'b10
    } dec_state_t;

endpackage : tx_cmd_pkg

/* File: include/tx_cmd_if.sv */
// Purpose: word link from host end to command decoder
// Assumes: both ends on one clock
// Notes:   word moves when word_valid and word_ready are both high
`timescale 1ns/100ps
interface tx_cmd_if;
    logic        word_valid;
    logic        word_ready;
    logic [31:0] word_data;
    logic        loaded;
    logic        tx_err;
    logic        pkt_open;

    modport dev  (input word_valid, input word_data, output word_ready,
                  output loaded, output tx_err, output pkt_open);
    modport host (output word_valid, output word_data, input word_ready,
                  input loaded, input tx_err, input pkt_open);
endinterface : tx_cmd_if

/* File: design/tx_cmd_decoder.sv */
// Purpose: decode command words, strip offset and padding, check packet length
// Assumes: words arrive in order command one, command two, data
// Notes:   no back-pressure; one data word accepted per cycle
`timescale 1ns/100ps
module tx_cmd_decoder (
    input  wire logic        clock,
    input  wire logic        rst,
    tx_cmd_if.dev            link,
    output logic      [31:0] out_data,
    output logic      [3:0]  out_be,
    output logic             out_valid,
    output logic             out_last
);

    // ********
    // state
    // ********
    typedef struct packed {
        tx_cmd_pkg::dec_state_t st;
        logic                   ready;
        logic                   ioc;
        logic                   first;
        logic                   last;
        logic [4:0]             off;
        logic [10:0]            size;
        logic [9:0]             total;
        logic [9:0]             idx;
        logic [10:0]            len;
        logic [15:0]            cnt;
        logic                   open;
        logic                   loaded;
        logic                   err;
        logic [31:0]            odata;
        logic [3:0]             obe;
        logic                   ovalid;
        logic                   olast;
    } dec_t;

    dec_t dec_r;
    dec_t dec_nxt;

    // ********
    // helpers
    // ********

    // words the host sends: offset plus size, rounded to the alignment
    function automatic logic [9:0] dword_total(
        input logic [4:0]  off,
        input logic [10:0] size,
        input logic [1:0]  align
    );
        logic [11:0] need;
        logic [11:0] m;
        need = (12'(off) + 12'(size) + 12'h003) >> 2;
        // reserved code 11 falls back to plain word alignment
        if (align == tx_cmd_pkg::ALIGN_16) begin
            m = tx_cmd_pkg::MASK_16;
        end else if (align == tx_cmd_pkg::ALIGN_32) begin
            m = tx_cmd_pkg::MASK_32;
        end else begin
            m = tx_cmd_pkg::MASK_4;
        end
        return 10'((need + m) & ~m);
    endfunction : dword_total

    // lanes of a data word that fall inside offset..offset+size
    function automatic logic [3:0] lane_mask(
        input logic [9:0]  idx,
        input logic [4:0]  off,
        input logic [10:0] size
    );
        logic [11:0] pos;
        logic [11:0] lo;
        logic [11:0] hi;
        lo = 12'(off);
        hi = 12'(off) + 12'(size);
        for (int k = 0; k < 4; k++) begin
            pos = {idx, 2'b00} + 12'(k);
            lane_mask[k] = (pos >= lo) && (pos < hi);
        end
    endfunction : lane_mask

    // ********
    // next state
    // ********
    logic        take;
    logic        done;
    logic [31:0] w;
    logic [3:0]  be;

    // one decision per accepted word
    always_comb begin
        dec_nxt        = dec_r;
        dec_nxt.ready  = 1'b1;
        dec_nxt.loaded = 1'b0;
        dec_nxt.err    = 1'b0;
        dec_nxt.ovalid = 1'b0;
        dec_nxt.olast  = 1'b0;
        dec_nxt.obe    = 4'h0;
        done           = 1'b0;
        w              = link.word_data;
        take           = dec_r.ready && link.word_valid;
        be             = lane_mask(dec_r.idx, dec_r.off, dec_r.size);

        unique case (dec_r.st)
            tx_cmd_pkg::ST_CMD_A: begin
                // reserved bits are not checked; the host keeps them zero
                if (take) begin
                    dec_nxt.ioc   = w[tx_cmd_pkg::IOC_BIT];
                    dec_nxt.first = w[tx_cmd_pkg::FIRST_BIT];
                    dec_nxt.last  = w[tx_cmd_pkg::LAST_BIT];
                    dec_nxt.off   = w[tx_cmd_pkg::OFF_HI:tx_cmd_pkg::OFF_LO];
                    dec_nxt.size  = w[tx_cmd_pkg::SIZE_HI:0];
                    dec_nxt.total = dword_total(w[tx_cmd_pkg::OFF_HI:tx_cmd_pkg::OFF_LO],
                                                w[tx_cmd_pkg::SIZE_HI:0],
                                                w[tx_cmd_pkg::ALIGN_HI:tx_cmd_pkg::ALIGN_LO]);
                    dec_nxt.idx   = 10'h000;
                    if (w[tx_cmd_pkg::FIRST_BIT]) begin
                        // a packet still open lost its closing buffer
                        dec_nxt.err  = dec_r.open;
                        dec_nxt.open = 1'b1;
                        dec_nxt.cnt  = 16'(w[tx_cmd_pkg::SIZE_HI:0]);
                    end else begin
                        // a middle buffer with no packet open is an error
                        dec_nxt.err  = !dec_r.open;
                        dec_nxt.cnt  = dec_r.cnt + 16'(w[tx_cmd_pkg::SIZE_HI:0]);
                    end
                    dec_nxt.st = tx_cmd_pkg::ST_CMD_B;
                end
            end
            tx_cmd_pkg::ST_CMD_B: begin
                if (take) begin
                    // later buffers must repeat the same length
                    if (dec_r.first) begin
                        dec_nxt.len = w[tx_cmd_pkg::LEN_HI:0];
                    end else if (w[tx_cmd_pkg::LEN_HI:0] != dec_r.len) begin
                        dec_nxt.err = 1'b1;
                    end
                    if (dec_r.total == 10'h000) begin
                        done = 1'b1;
                    end else begin
                        dec_nxt.st = tx_cmd_pkg::ST_DATA;
                    end
                end
            end
            tx_cmd_pkg::ST_DATA: begin
                // padding words and leading offset bytes carry no lanes
                if (take) begin
                    dec_nxt.odata  = w;
                    dec_nxt.obe    = be;
                    dec_nxt.ovalid = |be;
                    dec_nxt.idx    = dec_r.idx + 10'h001;
                    if (dec_r.idx == dec_r.total - 10'h001) begin
                        done          = 1'b1;
                        dec_nxt.olast = dec_r.last;
                    end
                end
            end
            default: begin
                dec_nxt.st = tx_cmd_pkg::ST_CMD_A;
            end
        endcase

        // end of buffer: report, close packet, check the byte total
        if (done) begin
            dec_nxt.st     = tx_cmd_pkg::ST_CMD_A;
            dec_nxt.loaded = dec_r.ioc;
            if (dec_r.last) begin
                dec_nxt.open = 1'b0;
                if (dec_nxt.cnt != 16'(dec_nxt.len)) begin
                    dec_nxt.err = 1'b1;
                end
            end
        end
    end

    // ********
    // registers
    // ********

    // whole state in one register; zero is a legal idle state
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            dec_r <= '0;
        end else begin
            dec_r <= dec_nxt;
        end
    end

    // outputs straight from the state register
    assign link.word_ready = dec_r.ready;
    assign link.loaded     = dec_r.loaded;
    assign link.tx_err     = dec_r.err;
    assign link.pkt_open   = dec_r.open;
    assign out_data        = dec_r.odata;
    assign out_be          = dec_r.obe;
    assign out_valid       = dec_r.ovalid;
    assign out_last        = dec_r.olast;

endmodule : tx_cmd_decoder

/* File: design/tx_cmd_host.sv */
// Purpose: AXI4-Lite slave that feeds command and data words to the decoder
// Assumes: one write and one read outstanding at most
// Notes:   interrupt status is sticky, cleared by writing one
`timescale 1ns/100ps
module tx_cmd_host (
    input  wire logic        clock,
    input  wire logic        rst,
    tx_cmd_if.host           link,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             irq
);

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        aw_got;
        logic        w_got;
        logic [7:0]  waddr;
        logic [31:0] wdata;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        lvalid;
        logic [31:0] ldata;
        logic [1:0]  sts;
        logic [1:0]  mask;
        logic        irq;
    } host_t;

    host_t host_r;
    host_t host_nxt;

    // address decode shared by read and write paths
    function automatic logic mapped(input logic [7:0] a);
        return (a == tx_cmd_pkg::REG_TX_WORD) || (a == tx_cmd_pkg::REG_INT_STATUS) ||
               (a == tx_cmd_pkg::REG_INT_MASK) || (a == tx_cmd_pkg::REG_LINK_STATE);
    endfunction : mapped

    // ********
    // next state
    // ********
    always_comb begin
        host_nxt = host_r;
        // address and data taken in either order
        if (s_axi_awvalid && host_r.awready) begin
            host_nxt.aw_got = 1'b1;
            host_nxt.waddr  = s_axi_awaddr;
        end
        if (s_axi_wvalid && host_r.wready) begin
            host_nxt.w_got = 1'b1;
            host_nxt.wdata = s_axi_wdata;
        end
        if (host_r.lvalid && link.word_ready) begin
            host_nxt.lvalid = 1'b0;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            host_nxt.bvalid = 1'b0;
        end
        // a word write stalls until the link slot is free
        if (host_r.aw_got && host_r.w_got && !host_r.bvalid) begin
            if (host_r.waddr != tx_cmd_pkg::REG_TX_WORD || !host_nxt.lvalid) begin
                host_nxt.aw_got = 1'b0;
                host_nxt.w_got  = 1'b0;
                host_nxt.bvalid = 1'b1;
                host_nxt.bresp  = mapped(host_r.waddr) ? tx_cmd_pkg::RESP_OKAY : tx_cmd_pkg::RESP_SLVERR;
                if (host_r.waddr == tx_cmd_pkg::REG_TX_WORD) begin
                    host_nxt.lvalid = 1'b1;
                    host_nxt.ldata  = host_r.wdata;
                end
                if (host_r.waddr == tx_cmd_pkg::REG_INT_STATUS) begin
                    host_nxt.sts = host_r.sts & ~host_r.wdata[1:0];
                end
                if (host_r.waddr == tx_cmd_pkg::REG_INT_MASK) begin
                    host_nxt.mask = host_r.wdata[1:0];
                end
            end
        end
        // new events set after the clear, so a same-cycle event survives
        host_nxt.sts[tx_cmd_pkg::STS_LOADED] = host_nxt.sts[tx_cmd_pkg::STS_LOADED] | link.loaded;
        host_nxt.sts[tx_cmd_pkg::STS_ERROR]  = host_nxt.sts[tx_cmd_pkg::STS_ERROR] | link.tx_err;
        host_nxt.irq = |(host_nxt.sts & host_nxt.mask);
        // read path
        if (s_axi_rvalid && s_axi_rready) begin
            host_nxt.rvalid = 1'b0;
        end
        if (s_axi_arvalid && host_r.arready) begin
            host_nxt.rvalid = 1'b1;
            host_nxt.rresp  = mapped(s_axi_araddr) ? tx_cmd_pkg::RESP_OKAY : tx_cmd_pkg::RESP_SLVERR;
            unique case (s_axi_araddr)
                tx_cmd_pkg::REG_INT_STATUS: host_nxt.rdata = {30'h0, host_r.sts};
                tx_cmd_pkg::REG_INT_MASK:   host_nxt.rdata = {30'h0, host_r.mask};
                tx_cmd_pkg::REG_LINK_STATE: host_nxt.rdata = {30'h0, link.pkt_open, host_r.lvalid};
                default:                    host_nxt.rdata = 32'h0;
            endcase
        end
        host_nxt.awready = !host_nxt.aw_got && !host_nxt.bvalid;
        host_nxt.wready  = !host_nxt.w_got && !host_nxt.bvalid;
        host_nxt.arready = !host_nxt.rvalid;
    end

    // ********
    // registers
    // ********
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            host_r <= '0;
        end else begin
            host_r <= host_nxt;
        end
    end

    assign s_axi_awready   = host_r.awready;
    assign s_axi_wready    = host_r.wready;
    assign s_axi_bvalid    = host_r.bvalid;
    assign s_axi_bresp     = host_r.bresp;
    assign s_axi_arready   = host_r.arready;
    assign s_axi_rvalid    = host_r.rvalid;
    assign s_axi_rdata     = host_r.rdata;
    assign s_axi_rresp     = host_r.rresp;
    assign link.word_valid = host_r.lvalid;
    assign link.word_data  = host_r.ldata;
    assign irq             = host_r.irq;

endmodule : tx_cmd_host

/* File: tb/tx_cmd_sva.sv */
// Purpose: checks on the word link between host end and decoder
// Assumes: one clock, rst asynchronous and active high
// Notes:   a shadow walk of each buffer marks its final word
`timescale 1ns/100ps
module tx_cmd_sva (
    input wire logic        clock,
    input wire logic        rst,
    input wire logic        word_valid,
    input wire logic        word_ready,
    input wire logic [31:0] word_data,
    input wire logic        loaded,
    input wire logic        tx_err,
    input wire logic        pkt_open
);
    // ********
    // shadow walk
    // ********
    logic [1:0]  st_r, al_r;
    logic [11:0] rem_r, sum_r, nw, msk;
    logic [10:0] plen_r, size_r, plen_eff;
    logic [4:0]  off_r;
    logic        ioc_r, fst_r, lst_r, open_r, bad_r, take, fin, end_ioc;

    // words per buffer, rounded up to the end alignment
    assign take     = word_valid && word_ready;
    assign msk      = (al_r == 2'h1) ? 12'h003 : ((al_r == 2'h2) ? 12'h007 : 12'h000);
    assign nw       = (((12'(off_r) + 12'(size_r) + 12'h003) >> 2) + msk) & ~msk;
    assign fin      = take && ((st_r == 2'h2 && rem_r == 12'h001) || (st_r == 2'h1 && nw == 12'h000));
    assign end_ioc  = fin && ioc_r;
    assign plen_eff = (st_r == 2'h1 && fst_r) ? word_data[10:0] : plen_r;

    // bad: packet already broken, no length verdict
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_r   <= 2'h0;
            rem_r  <= 12'h000;
            sum_r  <= 12'h000;
            plen_r <= 11'h000;
            open_r <= 1'b0;
            bad_r  <= 1'b0;
        end else if (take) begin
            case (st_r)
                2'h0: begin
                    st_r   <= 2'h1;
                    ioc_r  <= word_data[31];
                    al_r   <= word_data[25:24];
                    off_r  <= word_data[20:16];
                    fst_r  <= word_data[13];
                    lst_r  <= word_data[12];
                    size_r <= word_data[10:0];
                    sum_r  <= (word_data[13] ? 12'h000 : sum_r) + 12'(word_data[10:0]);
                    bad_r  <= word_data[13] ? open_r : (bad_r || !open_r);
                    open_r <= open_r || word_data[13];
                end
                2'h1: begin
                    st_r   <= (nw == 12'h000) ? 2'h0 : 2'h2;
                    rem_r  <= nw;
                    plen_r <= plen_eff;
                    bad_r  <= bad_r || (word_data[10:0] != plen_eff);
                end
                default: begin
                    st_r  <= (rem_r == 12'h001) ? 2'h0 : 2'h2;
                    rem_r <= rem_r - 12'h001;
                end
            endcase
            if (fin && lst_r) open_r <= 1'b0;
        end
    end

    // ********
    // link assertions
    // ********
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    a_loaded_on_end: assert property (end_ioc |=> loaded)
        else $error("buffer end without loaded pulse");
    a_loaded_cause: assert property (loaded |-> $past(end_ioc))
        else $error("loaded pulse away from a requested buffer end");
    a_loaded_single: assert property (loaded |=> !loaded)
        else $error("loaded longer than one cycle");
    a_err_on_mismatch: assert property (fin && lst_r && sum_r != {1'b0, plen_eff} |=> tx_err)
        else $error("length mismatch without error pulse");
    a_no_false_err: assert property (fin && lst_r && st_r == 2'h2 && !bad_r && sum_r == {1'b0, plen_r} |=> !tx_err)
        else $error("error pulse on a matching packet");
    a_err_after_take: assert property (tx_err |-> $past(take))
        else $error("error pulse not after a word");
    a_open_moves: assert property ($changed(pkt_open) |-> $past(take))
        else $error("packet state moved without a word");
    a_close_on_last: assert property (fin && lst_r |=> !pkt_open)
        else $error("packet still open after last buffer");
    a_open_on_first: assert property (take && st_r == 2'h0 && word_data[13] && !word_data[12] |-> ##[1:2] pkt_open)
        else $error("first buffer did not open a packet");
    a_ready_steady: assert property (!$past(rst) |-> word_ready)
        else $error("word link not ready");
endmodule : tx_cmd_sva

/* File: tb/tx_buffer_command_a_decoder_tb.sv */
// Purpose: bench for host end and decoder joined by the word link
// Assumes: register map of tx_cmd_pkg, one 250 MHz clock
// Notes:   results are matched against queued notes by a watcher
`timescale 1ns/100ps
module tx_buffer_command_a_decoder_tb;
    logic        clock, rst, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, irq, out_valid, out_last;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, out_data, seed;
    logic [1:0]  bresp, rresp;
    logic [3:0]  out_be;
    logic [11:0] sum;
    logic [39:0] link_q[$], bus_q[$];
    int          fails, compares;

    // ********
    // design, link and checker
    // ********
    tx_cmd_if link();
    tx_cmd_decoder u_tx_cmd_decoder (.clock(clock), .rst(rst), .link(link), .out_data(out_data),
        .out_be(out_be), .out_valid(out_valid), .out_last(out_last));
    tx_cmd_host u_tx_cmd_host (.clock(clock), .rst(rst), .link(link), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq));
    tx_cmd_sva u_tx_cmd_sva (.clock(clock), .rst(rst), .word_valid(link.word_valid),
        .word_ready(link.word_ready), .word_data(link.word_data), .loaded(link.loaded),
        .tx_err(link.tx_err), .pkt_open(link.pkt_open));

    // free-running clock
    initial clock = 1'b0;
    always #2 clock = ~clock;

    // ********
    // helpers
    // ********
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    function automatic logic [31:0] bmask(input logic [3:0] be);
        return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction : bmask

    task automatic check(input logic [39:0] got, input logic [39:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    // a result with no note left is a mismatch too
    task automatic pop_check(input logic sel, input logic [39:0] got);
        if ((sel ? link_q.size() : bus_q.size()) == 0) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, 40'h0);
        end else begin
            check(got, sel ? link_q.pop_front() : bus_q.pop_front());
        end
    endtask : pop_check

    task automatic summarize();
        $display("counts: compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : summarize

    // one write; each channel dropped at its own handshake; bready stays high
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        bus_q.push_back({2'h3, 4'h0, er, 32'h0});
        {awaddr, wdata, awvalid, wvalid} <= {a, d, 2'h3};
        do begin
            @(posedge clock);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
    endtask : axi_write

    task automatic axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        bus_q.push_back({2'h3, 4'h0, er, ed});
        {araddr, arvalid} <= {a, 1'b1};
        do begin
            @(posedge clock);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
    endtask : axi_read

    // irq is registered, so let the mask or clear settle first
    task automatic irq_is(input logic e);
        repeat (2) @(posedge clock);
        check({39'h0, irq}, {39'h0, e});
    endtask : irq_is

    // one buffer: both command words, then data padded to the end alignment
    task automatic send_buf(input logic ioc, input logic [1:0] al, input logic [4:0] off,
                            input logic [10:0] size, input logic fst, input logic lst, input logic [10:0] len);
        logic [11:0] nw, msk;
        logic [3:0]  be;
        logic [31:0] d;
        logic        fin;
        msk = (al == 2'h1) ? 12'h003 : ((al == 2'h2) ? 12'h007 : 12'h000);
        nw  = (((12'(off) + 12'(size) + 12'h003) >> 2) + msk) & ~msk;
        sum = (fst ? 12'h000 : sum) + 12'(size);
        d   = rnd();
        axi_write(tx_cmd_pkg::REG_TX_WORD, {ioc, 5'h00, al, 3'h0, off, 2'h0, fst, lst, 1'b0, size},
                  tx_cmd_pkg::RESP_OKAY);
        axi_write(tx_cmd_pkg::REG_TX_WORD, {d[15:0], 5'h00, len}, tx_cmd_pkg::RESP_OKAY);
        for (int i = 0; i < int'(nw); i++) begin
            d   = rnd();
            fin = (i == int'(nw) - 1);
            for (int k = 0; k < 4; k++) be[k] = (4 * i + k >= off) && (4 * i + k < off + size);
            if (be != 4'h0 || (fin && lst)) link_q.push_back({2'h0, fin && lst, be, d & bmask(be), 1'b0});
            if (fin && ioc) link_q.push_back({2'h1, 38'h0});
            if (fin && lst && sum != 12'(len)) link_q.push_back({2'h2, 38'h0});
            axi_write(tx_cmd_pkg::REG_TX_WORD, d, tx_cmd_pkg::RESP_OKAY);
        end
    endtask : send_buf

    // watcher: bus answers and link results against the oldest note
    always @(posedge clock) begin
        if (!rst) begin
            if (bvalid && bready) pop_check(1'b0, {2'h3, 4'h0, bresp, 32'h0});
            if (rvalid && rready) pop_check(1'b0, {2'h3, 4'h0, rresp, rdata});
            if (out_valid || out_last) pop_check(1'b1, {2'h0, out_last, out_be, out_data & bmask(out_be), 1'b0});
            if (link.loaded) pop_check(1'b1, {2'h1, 38'h0});
            if (link.tx_err) pop_check(1'b1, {2'h2, 38'h0});
        end
    end

    // watchdog, far beyond the test length
    initial begin
        repeat (20000) @(posedge clock);
        fails++;
        summarize();
    end

    // ********
    // tests
    // ********
    initial begin
        logic [31:0] r;
        {awvalid, wvalid, arvalid, bready, rready} = 5'h03;
        {awaddr, araddr, wdata} = 48'h0;
        {seed, sum, fails, compares} = {32'h1862, 12'h000, 64'h0};
        rst = 1'b1;
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        repeat (2) @(posedge clock);
        for (int a = 0; a < 4; a++) begin
            r = rnd();
            send_buf(1'b1, 2'(a), r[4:0], 11'(r[13:8]) + 11'h001, 1'b1, 1'b1, 11'(r[13:8]) + 11'h001);
        end
        send_buf(1'b1, 2'h2, 5'h1F, 11'h001, 1'b1, 1'b1, 11'h001);
        send_buf(1'b0, 2'h2, 5'h00, 11'h004, 1'b1, 1'b1, 11'h004);
        $display("done: alignment and offset");
        send_buf(1'b0, 2'h1, 5'h03, 11'h005, 1'b1, 1'b0, 11'h012);
        axi_read(tx_cmd_pkg::REG_LINK_STATE, 32'h2, tx_cmd_pkg::RESP_OKAY);
        send_buf(1'b0, 2'h0, 5'h06, 11'h006, 1'b0, 1'b0, 11'h012);
        send_buf(1'b0, 2'h2, 5'h00, 11'h007, 1'b0, 1'b1, 11'h012);
        axi_read(tx_cmd_pkg::REG_LINK_STATE, 32'h0, tx_cmd_pkg::RESP_OKAY);
        $display("done: segmented packet");
        send_buf(1'b0, 2'h0, 5'h01, 11'h00A, 1'b1, 1'b1, 11'h00C);
        send_buf(1'b0, 2'h0, 5'h02, 11'h004, 1'b1, 1'b0, 11'h009);
        send_buf(1'b0, 2'h1, 5'h00, 11'h004, 1'b0, 1'b1, 11'h009);
        $display("done: length errors");
        axi_read(tx_cmd_pkg::REG_INT_STATUS, 32'h3, tx_cmd_pkg::RESP_OKAY);
        irq_is(1'b0);
        axi_write(tx_cmd_pkg::REG_INT_MASK, 32'h1, tx_cmd_pkg::RESP_OKAY);
        irq_is(1'b1);
        axi_write(tx_cmd_pkg::REG_INT_STATUS, 32'h1, tx_cmd_pkg::RESP_OKAY);
        axi_read(tx_cmd_pkg::REG_INT_STATUS, 32'h2, tx_cmd_pkg::RESP_OKAY);
        irq_is(1'b0);
        axi_write(tx_cmd_pkg::REG_INT_MASK, 32'h3, tx_cmd_pkg::RESP_OKAY);
        irq_is(1'b1);
        axi_write(tx_cmd_pkg::REG_INT_STATUS, 32'h2, tx_cmd_pkg::RESP_OKAY);
        irq_is(1'b0);
        axi_read(tx_cmd_pkg::REG_INT_MASK, 32'h3, tx_cmd_pkg::RESP_OKAY);
        $display("done: interrupts");
        axi_write(8'h10, 32'hFFFFFFFF, tx_cmd_pkg::RESP_SLVERR);
        axi_read(8'h10, 32'h0, tx_cmd_pkg::RESP_SLVERR);
        $display("done: unmapped address");
        repeat (4) @(posedge clock);
        check(40'(link_q.size() + bus_q.size()), 40'h0);
        summarize();
    end
endmodule : tx_buffer_command_a_decoder_tb
